// ==== include/cascq_pkg.sv ====
// Purpose: Shared constants and types for the cascadable acknowledge/AEOI controller
// Assumes: Eight request lines, three-bit slave-select bus
// Notes:   Priority is fixed, line 0 highest
package cascq_pkg;
  localparam int          NLINES     = 8;
  localparam int          SEL_W      = 3;
  localparam int          BASE_W     = 5;
  localparam logic [2:0]  SPUR_LEVEL = 3'h7;
  localparam logic [2:0]  SEL_IDLE   = 3'h0;
  localparam logic [7:0]  LINES_ZERO = 8'h00;

  // Gray order along IDLE -> ACK1 -> GAP -> ACK2 -> IDLE
  typedef enum logic [1:0] {
    CASCQ_IDLE = 2'b00,
    CASCQ_ACK1 = 2'b01,
    CASCQ_GAP  = 2'b11,
    CASCQ_ACK2 = 2'b10
  } cascq_state_t;

  typedef struct packed {
    logic              aeoi;
    logic              slave_mode;
    logic [SEL_W-1:0]  slave_id;
    logic [NLINES-1:0] cascade;
    logic [NLINES-1:0] mask;
    logic [BASE_W-1:0] vector_base;
  } cascq_cfg_t;

  typedef struct packed {
    cascq_state_t      state;
    logic              prev_ack;
    logic [NLINES-1:0] prev_req;
    logic [NLINES-1:0] irr;
    logic [NLINES-1:0] isr;
    logic [SEL_W-1:0]  cur;
    logic              cur_valid;
    logic              involved;
    logic [SEL_W-1:0]  sel;
    logic              sel_oe;
    logic [7:0]        data;
    logic              data_oe;
    logic              int_req;
  } cascq_regs_t;
endpackage

// ==== verilog/cascq_ctrl.sv ====
// Purpose: Request latch, masking, acknowledge sequencing, cascade select and AEOI for one controller
// Assumes: Acknowledge strobe and request inputs are synchronous to SYS_CLK_I
// Notes:   Same module serves as master or slave, chosen by CFG_I.slave_mode

module cascq_ctrl (
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          RESETN_I,
  input  wire cascq_pkg::cascq_cfg_t         CFG_I,
  input  wire logic [cascq_pkg::NLINES-1:0]  REQUEST_INPUT_I,
  input  wire logic                          ACK_PULSE_N_I,
  input  wire logic                          EOI_NONSPEC_I,
  input  wire logic [cascq_pkg::SEL_W-1:0]   SLAVE_SELECT_BUS_I,
  output logic      [cascq_pkg::SEL_W-1:0]   SLAVE_SELECT_BUS_O,
  output logic                               SLAVE_SELECT_OE_O,
  output logic                               INT_REQ_O,
  output logic      [7:0]                    DATA_O,
  output logic                               DATA_OE_O,
  output logic      [cascq_pkg::NLINES-1:0]  PENDING_O,
  output logic      [cascq_pkg::NLINES-1:0]  IN_SERVICE_O
);
  import cascq_pkg::*;

  // Lowest set index wins; returns {valid, index}
  function automatic logic [3:0] first_set(input logic [NLINES-1:0] v);
    logic [3:0] res;
    res = 4'h0;
    for (int i = NLINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  cascq_regs_t       r;
  cascq_regs_t       n;
  logic              ack_fall;
  logic              ack_rise;
  logic [3:0]        win;
  logic [3:0]        top_isr;
  logic              win_ok;
  logic              selected;
  logic [NLINES-1:0] clr_isr;
  logic [NLINES-1:0] set_isr;
  logic [NLINES-1:0] clr_irr;

  assign ack_fall = r.prev_ack & ~ACK_PULSE_N_I;
  assign ack_rise = ~r.prev_ack & ACK_PULSE_N_I;
  // Cascade bits take no part in resolution
  assign win      = first_set(r.irr & ~CFG_I.mask);
  assign top_isr  = first_set(r.isr);
  assign win_ok   = win[3] && (!top_isr[3] || (win[2:0] < top_isr[2:0]));
  // A slave reads the select bus at the first rise, since the master only drives it
  // one clock after the first fall; the frozen winner is taken at that point
  assign selected = CFG_I.slave_mode
                    ? (r.state == CASCQ_ACK1 && ack_rise && SLAVE_SELECT_BUS_I == CFG_I.slave_id)
                    : (r.state == CASCQ_IDLE && ack_fall);

  always_comb begin
    n          = r;
    clr_isr    = LINES_ZERO;
    set_isr    = LINES_ZERO;
    clr_irr    = ~REQUEST_INPUT_I;
    n.prev_ack = ACK_PULSE_N_I;
    n.prev_req = REQUEST_INPUT_I;
    case (r.state)
      CASCQ_IDLE: begin
        if (ack_fall) begin
          n.state    = CASCQ_ACK1;
          n.involved = 1'b0;
        end
      end
      CASCQ_ACK1: begin
        if (ack_rise) begin
          n.state = CASCQ_GAP;
        end
      end
      CASCQ_GAP: begin
        if (ack_fall) begin
          n.state = CASCQ_ACK2;
          // Master stays off the bus when a slave owns the vector
          if (r.involved && !r.sel_oe) begin
            n.data_oe = 1'b1;
            n.data    = {CFG_I.vector_base, r.cur};
          end
        end
      end
      CASCQ_ACK2: begin
        if (ack_rise) begin
          n.state   = CASCQ_IDLE;
          n.data_oe = 1'b0;
          n.sel     = SEL_IDLE;
          n.sel_oe  = 1'b0;
          if (CFG_I.aeoi && r.involved && r.cur_valid) begin
            clr_isr[r.cur] = 1'b1;
          end
        end
      end
      default: begin
        n.state = CASCQ_IDLE;
      end
    endcase
    if (selected) begin
      n.involved  = 1'b1;
      // Winner frozen here; later request changes cannot alter it
      n.cur       = win_ok ? win[2:0] : SPUR_LEVEL;
      n.cur_valid = win_ok;
      if (win_ok) begin
        clr_irr[win[2:0]] = 1'b1;
        set_isr[win[2:0]] = 1'b1;
        if (!CFG_I.slave_mode && CFG_I.cascade[win[2:0]]) begin
          n.sel    = win[2:0];
          n.sel_oe = 1'b1;
        end
      end
    end
    if (EOI_NONSPEC_I && top_isr[3]) begin
      clr_isr[top_isr[2:0]] = 1'b1;
    end
    // Sets win over clears in the same cycle
    n.irr     = (r.irr & ~clr_irr) | (REQUEST_INPUT_I & ~r.prev_req);
    n.isr     = (r.isr & ~clr_isr) | set_isr;
    // Dropped for the whole acknowledge, so surely low in the second pulse
    n.int_req = (r.state == CASCQ_IDLE) && !ack_fall && win_ok;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      r          <= '0;
      r.state    <= CASCQ_IDLE;
      r.prev_ack <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign SLAVE_SELECT_BUS_O = r.sel;
  assign SLAVE_SELECT_OE_O  = r.sel_oe;
  assign INT_REQ_O          = r.int_req;
  assign DATA_O             = r.data;
  assign DATA_OE_O          = r.data_oe;
  assign PENDING_O          = r.irr;
  assign IN_SERVICE_O       = r.isr;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  property p_aeoi_clear;
    (r.state == CASCQ_ACK2 && ack_rise && CFG_I.aeoi && r.involved && r.cur_valid)
      |=> !r.isr[$past(r.cur)];
  endproperty
  a_aeoi_clear: assert property (p_aeoi_clear) else $error("AEOI did not clear in-service bit");

  property p_masked_no_req;
    r.int_req |-> |($past(r.irr) & ~$past(CFG_I.mask));
  endproperty
  a_masked_no_req: assert property (p_masked_no_req) else $error("Request raised from masked line");

  property p_sel_idle;
    (r.state == CASCQ_IDLE) |-> (r.sel == SEL_IDLE && !r.sel_oe);
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("Select bus active outside acknowledge");

  property p_sel_cascaded;
    (r.state == CASCQ_IDLE && ack_fall && !CFG_I.slave_mode && win_ok && CFG_I.cascade[win[2:0]])
      |=> (r.sel_oe && r.sel == $past(win[2:0]));
  endproperty
  a_sel_cascaded: assert property (p_sel_cascaded) else $error("Select bus wrong for cascaded line");

  property p_first_ack;
    (selected && win_ok)
      |=> (r.isr[$past(win[2:0])] && !r.irr[$past(win[2:0])] && r.state != CASCQ_IDLE);
  endproperty
  a_first_ack: assert property (p_first_ack) else $error("Winner not placed in service");

  property p_data_only_selected;
    r.data_oe |-> (r.involved && !r.sel_oe);
  endproperty
  a_data_only_selected: assert property (p_data_only_selected) else $error("Data driven by wrong party");

  property p_vector_on_second;
    (r.state == CASCQ_GAP && ack_fall && r.involved && !r.sel_oe)
      |=> (r.data_oe && r.data[2:0] == $past(r.cur)) ##1 (r.data_oe || r.state == CASCQ_IDLE);
  endproperty
  a_vector_on_second: assert property (p_vector_on_second) else $error("Vector not driven on second ack");

  property p_req_low_ack2;
    (r.state == CASCQ_ACK2) |-> !r.int_req;
  endproperty
  a_req_low_ack2: assert property (p_req_low_ack2) else $error("CPU request high in second pulse");

  property p_spurious;
    (selected && !win_ok)
      |=> (!r.sel_oe && r.cur == SPUR_LEVEL && r.isr == $past(r.isr));
  endproperty
  a_spurious: assert property (p_spurious) else $error("Spurious acknowledge mishandled");

  property p_nonspec_eoi;
    (EOI_NONSPEC_I && top_isr[3] && !selected) |=> !r.isr[$past(top_isr[2:0])];
  endproperty
  a_nonspec_eoi: assert property (p_nonspec_eoi) else $error("EOI left top in-service bit");

  c_cascaded_ack: cover property (r.state == CASCQ_ACK1 && r.sel_oe);
  c_slave_vector: cover property (CFG_I.slave_mode && r.data_oe);
  c_spurious_ack: cover property (r.state == CASCQ_ACK2 && !r.cur_valid && r.data_oe);
  c_aeoi_done:    cover property (CFG_I.aeoi && r.state == CASCQ_ACK2 && ack_rise);
endmodule // cascq_ctrl

// ==== bench/cascq_cpu_model.sv ====
// Purpose: CPU side of the two-pulse acknowledge
// Assumes: Strobe changes just after a rising edge
// Notes:   Hold sets pulse width, so prompt and slow CPUs
module cascq_cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_i,
  output logic            ack_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial ack_n_o = 1'b1;
  // Fall, rise, fall, rise; vector taken before last rise
  task automatic ack_cycle(input int hold, output logic [7:0] vec);
    @(posedge clk_i) #1 ack_n_o = 1'b0;
    repeat (hold) @(posedge clk_i);
    #1 ack_n_o = 1'b1;
    repeat (hold) @(posedge clk_i);
    #1 ack_n_o = 1'b0;
    repeat (hold + 1) @(posedge clk_i);
    #1 vec = bus_i;
    ack_n_o = 1'b1;
    repeat (hold + 1) @(posedge clk_i);
    #1;
  endtask
endmodule // cascq_cpu_model

// ==== bench/cascq_ctrl_tb_top.sv ====
// Purpose: Self-checking bench, master plus one cascaded slave
// Assumes: Fixed priority, line 0 highest
// Notes:   Slave sits on master line 4
module cascq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cascq_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, eoi_m = 1'b0, eoi_s = 1'b0;
  logic [7:0] req = 8'h00, sreq = 8'h00, vec;
  cascq_cfg_t mcfg = '0, scfg = '0;
  logic [2:0] msel, sel_bus;
  logic       msel_oe, m_int, s_int, moe, soe, md_seen, ack_n;
  logic [7:0] mdata, sdata, bus, mpend, misr, sisr;
  logic [3:0] selx;
  int         errors = 0, n_compared = 0;
  always #5 clk = ~clk;
  // Idle select bus reads low; released data bus floats
  assign sel_bus = msel_oe ? msel : SEL_IDLE;
  assign bus = moe ? mdata : (soe ? sdata : 8'hzz);
  always @(posedge clk) begin
    if (msel_oe) selx <= {1'b1, msel};
    if (moe) md_seen <= 1'b1;
  end
  cascq_ctrl DUT (.SYS_CLK_I(clk), .RESETN_I(rstn), .CFG_I(mcfg), .REQUEST_INPUT_I({req[7:5], s_int, req[3:0]}),
    .ACK_PULSE_N_I(ack_n), .EOI_NONSPEC_I(eoi_m), .SLAVE_SELECT_BUS_I(SEL_IDLE), .SLAVE_SELECT_BUS_O(msel),
    .SLAVE_SELECT_OE_O(msel_oe), .INT_REQ_O(m_int), .DATA_O(mdata), .DATA_OE_O(moe), .PENDING_O(mpend),
    .IN_SERVICE_O(misr));
  cascq_ctrl DUT_S (.SYS_CLK_I(clk), .RESETN_I(rstn), .CFG_I(scfg), .REQUEST_INPUT_I(sreq),
    .ACK_PULSE_N_I(ack_n), .EOI_NONSPEC_I(eoi_s), .SLAVE_SELECT_BUS_I(sel_bus), .SLAVE_SELECT_BUS_O(),
    .SLAVE_SELECT_OE_O(), .INT_REQ_O(s_int), .DATA_O(sdata), .DATA_OE_O(soe), .PENDING_O(),
    .IN_SERVICE_O(sisr));
  cascq_cpu_model cpu (.clk_i(clk), .bus_i(bus), .ack_n_o(ack_n));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_int(input logic exp);
    for (int k = 0; k < 40 && m_int !== exp; k++) @(posedge clk) #1;
    check("int_req", {7'h00, exp}, {7'h00, m_int});
    if (m_int !== exp) report_and_stop();
  endtask
  task automatic pulse(input logic slv);
    @(posedge clk) #1 {eoi_s, eoi_m} = {slv, ~slv};
    @(posedge clk) #1 {eoi_s, eoi_m} = 2'b00;
  endtask
  task automatic serve(input logic [7:0] exp_vec, input logic [3:0] exp_sel);
    {selx, md_seen} = 5'h00;
    cpu.ack_cycle($urandom_range(3, 1), vec);
    check("vector", exp_vec, vec);
    check("select", {4'h0, exp_sel}, {4'h0, selx});
    check("master_data_oe", {7'h00, exp_sel == 4'h0}, {7'h00, md_seen});
  endtask
  initial begin
    int ln;
    void'($urandom(32'hb42e));
    mcfg.cascade = 8'h10; // Slave off line 0, on line 4
    mcfg.vector_base = 5'h0a;
    scfg.slave_mode = 1'b1; // Slave keeps AEOI off
    scfg.slave_id = 3'h4;
    scfg.vector_base = 5'h15;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ln = $urandom_range(7, 0);
      if (ln == 4) ln = 0;
      @(posedge clk) #1 mcfg.aeoi = i[0];
      req[ln] = 1'b1;
      wait_int(1'b1);
      check("pending", 8'h01 << ln, mpend);
      serve({5'h0a, 3'(ln)}, 4'h0);
      check("in_service", i[0] ? 8'h00 : 8'h01 << ln, misr);
      if (!i[0]) pulse(1'b0);
      check("cleared", 8'h00, misr | mpend);
      req[ln] = 1'b0;
    end
    @(posedge clk) #1 mcfg.mask = 8'h08;
    req[3] = 1'b1;
    repeat (3) @(posedge clk);
    #1 check("masked_pending", 8'h08, mpend);
    check("masked_int", 8'h00, {7'h00, m_int});
    @(posedge clk) #1 {mcfg.aeoi, req[5]} = 2'b01;
    wait_int(1'b1);
    serve({5'h0a, 3'h5}, 4'h0);
    req[6] = 1'b1;
    repeat (3) @(posedge clk);
    #1 check("blocked_int", 8'h00, {7'h00, m_int});
    req[1] = 1'b1;
    wait_int(1'b1);
    serve({5'h0a, 3'h1}, 4'h0);
    pulse(1'b0);
    check("nested_isr", 8'h20, misr);
    pulse(1'b0);
    wait_int(1'b1);
    serve({5'h0a, 3'h6}, 4'h0);
    pulse(1'b0);
    req = 8'h08;
    // Request gone before the acknowledge
    @(posedge clk) #1 req[2] = 1'b1;
    wait_int(1'b1);
    req[2] = 1'b0;
    serve({5'h0a, 3'h7}, 4'h0);
    check("spurious_isr", 8'h00, misr);
    sreq[2] = 1'b1;
    wait_int(1'b1);
    serve({5'h15, 3'h2}, 4'hc);
    check("master_isr", 8'h10, misr);
    check("slave_isr", 8'h04, sisr);
    pulse(1'b0); // Master first, then slave
    pulse(1'b1);
    check("all_cleared", 8'h00, misr | sisr);
    report_and_stop();
  end
endmodule // cascq_ctrl_tb_top
